// *** inc/pbr_pkg.sv ***
// power budget reporting: shared constants, field layout and types
// assumes a 32-bit APB slave port and a 12-bit configuration offset space
//
// What this block does
// RULE1 - header low half returns power budget ID
// RULE2 - header version field always reads one
// RULE3 - upstream port next pointer resets to 230h
// RULE4 - downstream port next pointer resets to 230h, reads 220h once the strap is caught three edges after release
// RULE5 - index resets zero; zero selects D0 maximum
// RULE6 - index one selects D0 sustained record
// RULE7 - other index values report zero budget
// RULE8 - base power defaults four, loader may replace
// RULE9 - scale field resets to zero
// RULE10 - sub state field resets to zero
// RULE11 - power state field resets to D0
// RULE12 - type field resets to maximum power
// RULE13 - power rail field resets to 010b
// RULE14 - system included bit resets clear, loadable
// RULE15 - reserved bits read zero, writes ignored
// RULE16 - data follows index one cycle later
package pbr_pkg;

    // address map
    localparam int          PBR_ADDR_W   = 12;
    localparam logic [11:0] PBR_OFF_HDR  = 12'h20c;
    localparam logic [11:0] PBR_OFF_IDX  = 12'h210;
    localparam logic [11:0] PBR_OFF_DATA = 12'h214;
    localparam logic [11:0] PBR_OFF_SYS  = 12'h218;

    // capability header fields
    localparam logic [15:0] PBR_CAP_ID   = 16'h0004;
    localparam logic [3:0]  PBR_CAP_VER  = 4'h1;
    localparam logic [11:0] PBR_NEXT_UP  = 12'h230;
    localparam logic [11:0] PBR_NEXT_DN  = 12'h220;

    // strap settle time, in clock edges after reset release
    localparam logic [1:0]  PBR_STRAP_WAIT = 2'h2;

    // record index
    localparam int          PBR_IDX_W    = 8;
    localparam logic [7:0]  PBR_IDX_RST  = 8'h00;
    localparam logic [7:0]  PBR_IDX_MAX  = 8'h00;
    localparam logic [7:0]  PBR_IDX_SUST = 8'h01;

    // record field defaults
    localparam logic [7:0]  PBR_BASE_DEF  = 8'h04;
    localparam logic [1:0]  PBR_SCALE_DEF = 2'h0;
    localparam logic [2:0]  PBR_SUB_DEF   = 3'h0;
    localparam logic [1:0]  PBR_PM_D0     = 2'h0;
    localparam logic [2:0]  PBR_TYPE_MAX  = 3'h7;
    localparam logic [2:0]  PBR_TYPE_SUST = 3'h1;
    localparam logic [2:0]  PBR_RAIL_DEF  = 3'h2;
    localparam logic        PBR_SYS_DEF   = 1'b0;

    // one power record as it sits in the data register
    typedef struct packed {
        logic [10:0] rsvd;
        logic [2:0]  rail;
        logic [2:0]  kind;
        logic [1:0]  pm_state;
        logic [2:0]  sub_state;
        logic [1:0]  scale;
        logic [7:0]  base;
    } pbr_rec_t;

    localparam pbr_rec_t PBR_REC_ZERO = '0;

    // apb answer state, one-hot
    typedef enum logic [1:0] {
        PBR_ST_IDLE = 2'b01,
        PBR_ST_RESP = 2'b10
    } pbr_state_t;

endpackage : pbr_pkg

// *** src/pbr_sync.sv ***
// two-flop synchroniser for a level from a pin
// assumes the level changes slowly compared with the clock
`timescale 1ns/1ps
`default_nettype none
module pbr_sync #(
    parameter logic RST_VAL = 1'b0
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic sys_rst_i,
    // level in and out
    input  wire logic async_i,
    output var  logic sync_o
);

    logic meta_q;

    // first stage is read only by the second stage
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule : pbr_sync
`default_nettype wire

// *** src/pbr_record.sv ***
// one power record with a loadable base power value
// assumes the loader strobe comes from logic on the same clock
`timescale 1ns/1ps
`default_nettype none
module pbr_record #(
    parameter logic [2:0] KIND = pbr_pkg::PBR_TYPE_MAX
) (
    // clock and reset
    input  wire logic            ref_clk_i,
    input  wire logic            sys_rst_i,
    // loader
    input  wire logic            ld_i,
    input  wire logic [7:0]      ld_base_i,
    // record
    output var  pbr_pkg::pbr_rec_t rec_o
);

    // read-only fields come up at their defaults; only base is loadable
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            rec_o           <= pbr_pkg::PBR_REC_ZERO;
            rec_o.base      <= pbr_pkg::PBR_BASE_DEF;   // RULE8
            rec_o.scale     <= pbr_pkg::PBR_SCALE_DEF;  // RULE9
            rec_o.sub_state <= pbr_pkg::PBR_SUB_DEF;    // RULE10
            rec_o.pm_state  <= pbr_pkg::PBR_PM_D0;      // RULE11
            rec_o.kind      <= KIND;                    // RULE12
            rec_o.rail      <= pbr_pkg::PBR_RAIL_DEF;   // RULE13
        end else if (ld_i) begin
            rec_o.base      <= ld_base_i;               // RULE8
        end
    end

endmodule : pbr_record
`default_nettype wire

// *** src/pbr_top.sv ***
// power budget reporting capability registers behind an APB slave
// assumes an APB master on ref_clk_i, a port-role strap pin and an
// eeprom loader that drives its strobes on the same clock
`timescale 1ns/1ps
`default_nettype none
module pbr_top #(
    parameter int ADDR_W = pbr_pkg::PBR_ADDR_W
) (
    // clock and reset
    input  wire logic              ref_clk_i,
    input  wire logic              sys_rst_i,
    // apb slave
    input  wire logic              psel_i,
    input  wire logic              penable_i,
    input  wire logic              pwrite_i,
    input  wire logic [ADDR_W-1:0] paddr_i,
    input  wire logic [31:0]       pwdata_i,
    input  wire logic [3:0]        pstrb_i,
    output var  logic [31:0]       prdata_o,
    output var  logic              pready_o,
    output var  logic              pslverr_o,
    // port role strap, high on the upstream port
    input  wire logic              upstream_port_i,
    // eeprom auto-load
    input  wire logic              ee_base_ld_i,
    input  wire logic              ee_base_sel_i,
    input  wire logic [7:0]        ee_base_i,
    input  wire logic              ee_sys_ld_i,
    input  wire logic              ee_sys_i,
    // state seen by the rest of the port
    output var  logic [7:0]        record_index_o,
    output var  pbr_pkg::pbr_rec_t budget_data_o,
    output var  logic              sys_included_o,
    output var  logic              is_upstream_o
);

    localparam int IW = pbr_pkg::PBR_IDX_W;

    pbr_pkg::pbr_state_t state_q;
    pbr_pkg::pbr_state_t state_d;
    pbr_pkg::pbr_rec_t   rec_max;
    pbr_pkg::pbr_rec_t   rec_sust;
    pbr_pkg::pbr_rec_t   data_d;
    logic [IW-1:0]       index_q;
    logic                up_sync;
    logic                strap_done_q;
    logic [1:0]          strap_cnt_q;
    logic                chk_rst_q;
    logic [11:0]         next_ptr;
    logic [31:0]         hdr_word;
    logic [31:0]         rd_word;
    logic                rd_hit;
    logic                setup_acc;
    logic                done_acc;
    logic                wr_done;
    logic                ld_max;
    logic                ld_sust;

    // strap pin crosses into the clock domain
    pbr_sync #(
        .RST_VAL (1'b1)
    ) u_strap_sync (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .async_i   (upstream_port_i),
        .sync_o    (up_sync)
    );

    // loader strobes steer to one record each
    assign ld_max  = ee_base_ld_i & ~ee_base_sel_i;
    assign ld_sust = ee_base_ld_i &  ee_base_sel_i;

    // d0 maximum record
    pbr_record #(
        .KIND (pbr_pkg::PBR_TYPE_MAX)
    ) u_rec_max (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .ld_i      (ld_max),
        .ld_base_i (ee_base_i),
        .rec_o     (rec_max)
    );

    // d0 sustained record
    pbr_record #(
        .KIND (pbr_pkg::PBR_TYPE_SUST)
    ) u_rec_sust (
        .ref_clk_i (ref_clk_i),
        .sys_rst_i (sys_rst_i),
        .ld_i      (ld_sust),
        .ld_base_i (ee_base_i),
        .rec_o     (rec_sust)
    );

    // port role is caught once, after the synchroniser has passed the strap through
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            is_upstream_o <= 1'b1;
            strap_done_q  <= 1'b0;
            strap_cnt_q   <= '0;
        end else if (strap_cnt_q != pbr_pkg::PBR_STRAP_WAIT) begin
            strap_cnt_q <= strap_cnt_q + 2'h1; // sync output still holds its reset value
        end else if (!strap_done_q) begin
            is_upstream_o <= up_sync;
            strap_done_q  <= 1'b1;
        end
    end

    // next pointer depends on port role
    assign next_ptr = is_upstream_o ? pbr_pkg::PBR_NEXT_UP  // RULE3
                                    : pbr_pkg::PBR_NEXT_DN; // RULE4

    // header word is constant apart from the pointer
    assign hdr_word = {next_ptr, pbr_pkg::PBR_CAP_VER, pbr_pkg::PBR_CAP_ID}; // RULE1 RULE2

    // apb phases: first access cycle fetches, second one completes
    assign setup_acc = psel_i & penable_i & (state_q == pbr_pkg::PBR_ST_IDLE);
    assign done_acc  = psel_i & penable_i & (state_q == pbr_pkg::PBR_ST_RESP);
    assign wr_done   = done_acc & pwrite_i & ~pslverr_o;

    // answer state: one wait cycle then ready
    always_comb begin
        case (state_q)
            pbr_pkg::PBR_ST_IDLE: state_d = setup_acc ? pbr_pkg::PBR_ST_RESP : pbr_pkg::PBR_ST_IDLE;
            pbr_pkg::PBR_ST_RESP: state_d = pbr_pkg::PBR_ST_IDLE;
            default:              state_d = pbr_pkg::PBR_ST_IDLE;
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            state_q <= pbr_pkg::PBR_ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // ready and error are registered with the answer
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            pready_o  <= 1'b0;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= setup_acc;
            pslverr_o <= setup_acc & ~rd_hit;
        end
    end

    // read decode; reserved bits are zero
    always_comb begin
        rd_word = '0;
        rd_hit  = 1'b1;
        case (paddr_i)
            pbr_pkg::PBR_OFF_HDR:  rd_word = hdr_word;                           // RULE1
            pbr_pkg::PBR_OFF_IDX:  rd_word = {{(32-IW){1'b0}}, index_q};         // RULE15
            pbr_pkg::PBR_OFF_DATA: rd_word = budget_data_o;
            pbr_pkg::PBR_OFF_SYS:  rd_word = {{31{1'b0}}, sys_included_o};       // RULE15
            default:               rd_hit  = 1'b0;
        endcase
    end

    // read data captured in the first access cycle, held while ready
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            prdata_o <= '0;
        end else if (setup_acc) begin
            prdata_o <= pwrite_i ? '0 : rd_word;
        end
    end

    // index is the only writable field; lane zero carries it
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            index_q <= pbr_pkg::PBR_IDX_RST; // RULE5
        end else if (wr_done && paddr_i == pbr_pkg::PBR_OFF_IDX && pstrb_i[0]) begin
            index_q <= pwdata_i[IW-1:0];     // RULE15
        end
    end

    assign record_index_o = index_q;

    // record chosen by the index
    always_comb begin
        case (index_q)
            pbr_pkg::PBR_IDX_MAX:  data_d = rec_max;             // RULE5
            pbr_pkg::PBR_IDX_SUST: data_d = rec_sust;            // RULE6
            default:               data_d = pbr_pkg::PBR_REC_ZERO; // RULE7
        endcase
    end

    // data register follows the index one cycle later
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            budget_data_o <= pbr_pkg::PBR_REC_ZERO;
        end else begin
            budget_data_o <= data_d; // RULE16
        end
    end

    // system included bit, settable only by the loader
    always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
            sys_included_o <= pbr_pkg::PBR_SYS_DEF; // RULE14
        end else if (ee_sys_ld_i) begin
            sys_included_o <= ee_sys_i;             // RULE14
        end
    end

    // reset seen one edge late, so no check starts on the release edge
    always_ff @(posedge ref_clk_i) begin
        chk_rst_q <= sys_rst_i;
    end

    // checks
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (sys_rst_i || chk_rst_q);

    sequence s_rd_fetch(logic [11:0] off);
        psel_i && penable_i && !pwrite_i && state_q == pbr_pkg::PBR_ST_IDLE && paddr_i == off;
    endsequence

    sequence s_idx_write;
        wr_done && paddr_i == pbr_pkg::PBR_OFF_IDX && pstrb_i[0];
    endsequence

    a_hdr_id_read: assert property ( // RULE1
        s_rd_fetch(pbr_pkg::PBR_OFF_HDR) |=> pready_o && prdata_o[15:0] == pbr_pkg::PBR_CAP_ID)
        else $error("header id wrong");

    a_hdr_ver_read: assert property ( // RULE2
        s_rd_fetch(pbr_pkg::PBR_OFF_HDR) |=> prdata_o[19:16] == pbr_pkg::PBR_CAP_VER)
        else $error("header version wrong");

    a_next_up_ptr: assert property ( // RULE3
        s_rd_fetch(pbr_pkg::PBR_OFF_HDR) ##0 is_upstream_o |=> prdata_o[31:20] == pbr_pkg::PBR_NEXT_UP)
        else $error("upstream next pointer wrong");

    a_next_dn_ptr: assert property ( // RULE4
        s_rd_fetch(pbr_pkg::PBR_OFF_HDR) ##0 !is_upstream_o |=> prdata_o[31:20] == pbr_pkg::PBR_NEXT_DN)
        else $error("downstream next pointer wrong");

    a_idx_max_sel: assert property ( // RULE5
        index_q == pbr_pkg::PBR_IDX_MAX |=> budget_data_o == $past(rec_max))
        else $error("index zero not maximum record");

    a_idx_sust_sel: assert property ( // RULE6
        index_q == pbr_pkg::PBR_IDX_SUST |=> budget_data_o == $past(rec_sust))
        else $error("index one not sustained record");

    a_idx_other_zero: assert property ( // RULE7
        index_q != pbr_pkg::PBR_IDX_MAX && index_q != pbr_pkg::PBR_IDX_SUST |=> budget_data_o == '0)
        else $error("unsupported index not zero");

    a_base_ld_takes: assert property ( // RULE8
        ld_max && index_q == pbr_pkg::PBR_IDX_MAX ##1 index_q == pbr_pkg::PBR_IDX_MAX
        |=> budget_data_o.base == $past(ee_base_i, 2))
        else $error("loaded base power not shown");

    a_max_fixed_flds: assert property ( // RULE9 RULE10 RULE11 RULE12 RULE13
        index_q == pbr_pkg::PBR_IDX_MAX |=> budget_data_o.scale == pbr_pkg::PBR_SCALE_DEF
        && budget_data_o.sub_state == pbr_pkg::PBR_SUB_DEF && budget_data_o.pm_state == pbr_pkg::PBR_PM_D0
        && budget_data_o.kind == pbr_pkg::PBR_TYPE_MAX && budget_data_o.rail == pbr_pkg::PBR_RAIL_DEF)
        else $error("maximum record fixed fields wrong");

    a_sys_only_ld: assert property ( // RULE14
        !ee_sys_ld_i |=> $stable(sys_included_o))
        else $error("system bit changed without load");

    a_idx_rsvd_zero: assert property ( // RULE15
        s_rd_fetch(pbr_pkg::PBR_OFF_IDX) |=> prdata_o[31:IW] == '0 && prdata_o[IW-1:0] == $past(index_q))
        else $error("index readback wrong");

    a_idx_wr_follow: assert property ( // RULE16
        s_idx_write |-> ##2 budget_data_o == (($past(pwdata_i[IW-1:0], 2) == pbr_pkg::PBR_IDX_MAX) ? $past(rec_max)
            : ($past(pwdata_i[IW-1:0], 2) == pbr_pkg::PBR_IDX_SUST) ? $past(rec_sust)
            : pbr_pkg::PBR_REC_ZERO))
        else $error("data did not follow index");

    a_slverr_unmap: assert property (
        setup_acc && !rd_hit |=> pready_o && pslverr_o)
        else $error("unmapped access not flagged");

    a_mapped_no_err: assert property ( // RULE15
        setup_acc && rd_hit |=> pready_o && !pslverr_o)
        else $error("mapped access flagged as error");

    a_ready_pulse: assert property (
        pready_o |=> !pready_o)
        else $error("ready held for more than one cycle");

    a_state_onehot: assert property (
        $onehot(state_q))
        else $error("answer state not one-hot");

    a_wr_rdata_zero: assert property ( // RULE15
        setup_acc && pwrite_i |=> prdata_o == '0)
        else $error("write answered with nonzero data");

    a_idx_wr_takes: assert property ( // RULE5 RULE15
        s_idx_write |=> index_q == $past(pwdata_i[IW-1:0]))
        else $error("index write not taken");

    a_idx_ro_keep: assert property ( // RULE15
        !(wr_done && paddr_i == pbr_pkg::PBR_OFF_IDX && pstrb_i[0]) |=> $stable(index_q))
        else $error("index changed without a write");

    a_data_rd_value: assert property ( // RULE16
        s_rd_fetch(pbr_pkg::PBR_OFF_DATA) |=> prdata_o == $past(budget_data_o))
        else $error("data readback wrong");

    a_sys_rd_value: assert property ( // RULE14 RULE15
        s_rd_fetch(pbr_pkg::PBR_OFF_SYS) |=> prdata_o == {31'h0, $past(sys_included_o)})
        else $error("system register readback wrong");

    a_sys_ld_takes: assert property ( // RULE14
        ee_sys_ld_i |=> sys_included_o == $past(ee_sys_i))
        else $error("system bit load not taken");

    a_base_hold: assert property ( // RULE8
        !ld_max && !ld_sust |=> $stable(rec_max.base) && $stable(rec_sust.base))
        else $error("base power changed without load");

    // sustained base load while that record is selected
    sequence s_sust_ld;
        ld_sust && index_q == pbr_pkg::PBR_IDX_SUST;
    endsequence

    a_sust_ld_takes: assert property ( // RULE8
        s_sust_ld ##1 index_q == pbr_pkg::PBR_IDX_SUST |=> budget_data_o.base == $past(ee_base_i, 2))
        else $error("loaded sustained base power not shown");

    a_sust_fixed_flds: assert property ( // RULE9 RULE10 RULE11 RULE13
        index_q == pbr_pkg::PBR_IDX_SUST |=> budget_data_o.scale == pbr_pkg::PBR_SCALE_DEF
        && budget_data_o.sub_state == pbr_pkg::PBR_SUB_DEF && budget_data_o.pm_state == pbr_pkg::PBR_PM_D0
        && budget_data_o.kind == pbr_pkg::PBR_TYPE_SUST && budget_data_o.rail == pbr_pkg::PBR_RAIL_DEF)
        else $error("sustained record fixed fields wrong");

    a_data_rsvd_zero: assert property ( // RULE15
        budget_data_o.rsvd == '0)
        else $error("data reserved bits not zero");

    a_role_held: assert property ( // RULE3 RULE4
        strap_done_q |=> $stable(is_upstream_o))
        else $error("port role changed after capture");

endmodule : pbr_top
`default_nettype wire

// *** verif/testbench.sv ***
// self-checking bench for the power budget reporting registers
// assumes pbr_top answers apb one cycle after the access fetch
`timescale 1ns/1ps
`default_nettype none
module testbench;
    // clock, reset and design inputs
    logic              ref_clk_i;
    logic              sys_rst_i;
    logic              psel_i;
    logic              penable_i;
    logic              pwrite_i;
    logic [11:0]       paddr_i;
    logic [31:0]       pwdata_i;
    logic [3:0]        pstrb_i;
    logic              upstream_port_i;
    logic              ee_base_ld_i;
    logic              ee_base_sel_i;
    logic [7:0]        ee_base_i;
    logic              ee_sys_ld_i;
    logic              ee_sys_i;
    // design outputs
    logic [31:0]       prdata_o;
    logic              pready_o;
    logic              pslverr_o;
    logic [7:0]        record_index_o;
    pbr_pkg::pbr_rec_t budget_data_o;
    logic              sys_included_o;
    logic              is_upstream_o;
    // bench state and reference model
    int                err_total;
    int                tests_run;
    logic [31:0]       seed;
    logic [31:0]       rd;
    logic              er;
    logic [31:0]       r;
    int                idx_m;
    int                base_m [2];
    int                sys_m;
    int                up_m;

    pbr_top u_dut (
        .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .upstream_port_i(upstream_port_i), .ee_base_ld_i(ee_base_ld_i), .ee_base_sel_i(ee_base_sel_i),
        .ee_base_i(ee_base_i), .ee_sys_ld_i(ee_sys_ld_i), .ee_sys_i(ee_sys_i),
        .record_index_o(record_index_o), .budget_data_o(budget_data_o),
        .sys_included_o(sys_included_o), .is_upstream_o(is_upstream_o)
    );

    // 125 MHz clock
    initial begin
        ref_clk_i = 1'b0;
        forever #4 ref_clk_i = ~ref_clk_i;
    end

    // xorshift source of stimulus values
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // expected header word for the current port role
    function automatic logic [31:0] exp_hdr();
        return {(up_m != 0) ? pbr_pkg::PBR_NEXT_UP : pbr_pkg::PBR_NEXT_DN, 4'h1, 16'h0004};
    endfunction : exp_hdr

    // expected data word: max record at 0, sustained at 1, zero otherwise
    function automatic logic [31:0] exp_data();
        if (idx_m > 1)
            return 32'h0;
        return {11'h0, 3'b010, (idx_m == 0) ? 3'b111 : pbr_pkg::PBR_TYPE_SUST, 2'b00, 3'b000, 2'b00,
                base_m[idx_m][7:0]};
    endfunction : exp_data

    // verdict and end of run
    task automatic results();
        if (err_total == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : results

    // compare one word
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // compare one flag
    task automatic chk1(input string what, input logic exp, input logic got);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic [3:0] st,
                       output logic [31:0] q, output logic e);
        int n;
        @(posedge ref_clk_i);
        psel_i    <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= wd;
        pstrb_i   <= st;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        for (n = 0; n < 20; n++) begin
            @(posedge ref_clk_i);
            if (pready_o === 1'b1)
                break;
        end
        if (n == 20) begin
            err_total++;
            $display("ERROR pready expected 1 seen timeout");
            results();
        end
        q = prdata_o;
        e = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb

    // read all four registers and compare with the model
    task automatic read_all();
        apb(1'b0, 12'h20c, 32'h0, 4'h0, rd, er);
        chk("header", exp_hdr(), rd);
        chk1("hdr_err", 1'b0, er);
        apb(1'b0, 12'h210, 32'h0, 4'h0, rd, er);
        chk("index", idx_m, rd);
        apb(1'b0, 12'h214, 32'h0, 4'h0, rd, er);
        chk("data", exp_data(), rd);
        apb(1'b0, 12'h218, 32'h0, 4'h0, rd, er);
        chk("sys_reg", sys_m, rd);
    endtask : read_all

    // reset with a given port role, strap settled well before release
    task automatic rst(input logic up);
        upstream_port_i <= up;
        sys_rst_i       <= 1'b1;
        repeat (6) @(posedge ref_clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge ref_clk_i);
        #1;
        up_m      = up;
        idx_m     = 0;
        sys_m     = 0;
        base_m[0] = 4;
        base_m[1] = 4;
    endtask : rst

    // index write, then the data port one cycle after the index lands
    task automatic wr_idx(input logic [31:0] v, input logic [3:0] st);
        apb(1'b1, 12'h210, v, st, rd, er);
        if (st[0])
            idx_m = v[7:0];
        @(posedge ref_clk_i);
        #1;
        chk("index_port", idx_m, record_index_o);
        chk("data_port", exp_data(), budget_data_o);
    endtask : wr_idx

    // main sequence
    initial begin
        err_total = 0;
        tests_run = 0;
        seed = 32'h897d5cd0;
        {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, pstrb_i} = '0;
        {ee_base_ld_i, ee_base_sel_i, ee_base_i, ee_sys_ld_i, ee_sys_i} = '0;
        sys_rst_i = 1'b1;
        upstream_port_i = 1'b1;
        rst(1'b1);
        chk1("upstream", 1'b1, is_upstream_o);
        chk("data_port", exp_data(), budget_data_o);
        chk1("sys_port", 1'b0, sys_included_o);
        read_all();
        // writes to read-only registers change nothing
        apb(1'b1, 12'h20c, rnd(), 4'hf, rd, er);
        apb(1'b1, 12'h214, rnd(), 4'hf, rd, er);
        apb(1'b1, 12'h218, 32'hffff_ffff, 4'hf, rd, er);
        chk("wr_rdata", 32'h0, rd);
        chk1("wr_err", 1'b0, er);
        read_all();
        // unmapped places answer with an error and zero
        apb(1'b1, 12'h21c, 32'hffff_ffff, 4'hf, rd, er);
        chk1("unmapped_err", 1'b1, er);
        apb(1'b0, 12'h208, 32'h0, 4'h0, rd, er);
        chk1("unmapped_err", 1'b1, er);
        chk("unmapped_data", 32'h0, rd);
        // boundary and random index values, upper bits ignored
        wr_idx(32'hffff_ff01, 4'hf);
        wr_idx(32'h0000_0002, 4'hf);
        wr_idx(32'h0000_0000, 4'hf);
        wr_idx(32'h0000_00ff, 4'hf);
        for (int i = 0; i < 12; i++) begin
            r = rnd();
            wr_idx({r[31:8], r[8] ? {7'h0, r[0]} : r[7:0]}, {r[11:9], r[8] | r[12]});
            read_all();
        end
        // eeprom loads of both base values and the system bit
        for (int i = 0; i < 6; i++) begin
            r = rnd();
            @(posedge ref_clk_i);
            ee_base_ld_i  <= 1'b1;
            ee_base_sel_i <= r[8];
            ee_base_i     <= r[7:0];
            ee_sys_ld_i   <= r[9];
            ee_sys_i      <= r[10];
            @(posedge ref_clk_i);
            ee_base_ld_i <= 1'b0;
            ee_sys_ld_i  <= 1'b0;
            base_m[r[8]] = r[7:0];
            if (r[9])
                sys_m = r[10];
            repeat (2) @(posedge ref_clk_i);
            #1;
            chk1("sys_port", sys_m, sys_included_o);
            wr_idx({31'h0, r[8]}, 4'h1);
            read_all();
        end
        // second reset as a downstream port restores defaults
        rst(1'b0);
        chk1("upstream", 1'b0, is_upstream_o);
        read_all();
        wr_idx(32'h1, 4'hf);
        results();
    end
endmodule : testbench
`default_nettype wire
